// ===== hdl/ecr_cal_bank.v
// Calibration and threshold register bank for the power datapaths
`timescale 1ns/1ps
`include "ecr_regs.vh"

module ecr_cal_bank #(
  parameter [1:0] VARIANT = `ECR_VAR_FUND
) (
  input  wire                          sys_clk,
  input  wire                          rst_b,
  input  wire [`ECR_ADDR_W-1:0]        reg_addr,
  input  wire                          reg_wr,
  input  wire                          reg_rd,
  input  wire [`ECR_WORD_W-1:0]        reg_wdata,
  output reg  [`ECR_WORD_W-1:0]        reg_rdata,
  output reg                           reg_hit,
  output wire [24*6-1:0]               total_active_cal,
  output wire [24*6-1:0]               total_reactive_cal,
  output wire [24*6-1:0]               fund_active_cal,
  output wire [24*6-1:0]               fund_reactive_cal,
  output wire [`ECR_THR_W-1:0]         apparent_power_threshold,
  output wire [`ECR_THR_W-1:0]         active_power_threshold,
  output wire [`ECR_REG_W-1:0]         reactive_power_threshold_high
);

  localparam N = `ECR_NUM_REGS;
  localparam [`ECR_ADDR_W-1:0] BASE = `ECR_BASE;

  // Storage; index is offset minus base
  reg  [`ECR_REG_W-1:0] bank_reg [0:N-1];
  wire [`ECR_WORD_W-1:0] fmt_word;
  wire [`ECR_ADDR_W-1:0] rel_addr;
  wire [4:0]             idx;
  wire                   in_range;
  wire                   idx_present;
  wire                   idx_signed;

  assign rel_addr = reg_addr - BASE;
  assign idx      = rel_addr[4:0];
  assign in_range = (reg_addr >= `ECR_BASE) && (reg_addr <= `ECR_LAST);

  // Location presence for the built variant
  function present_at;
    input [`ECR_ADDR_W-1:0] a;
    input [1:0]             v;
    begin
      present_at = 1'b1;
      // RQ3 reactive variants only
      if (a >= `ECR_PH_A_REA_GAIN && a <= `ECR_PH_C_REA_OFS)
        present_at = (v != `ECR_VAR_BASIC);
      // RQ4 fundamental gain A
      if (a == `ECR_PH_A_FACT_GAIN)
        present_at = (v == `ECR_VAR_FUND);
      // RQ5 fundamental active offsets
      if (a == `ECR_PH_A_FACT_OFS || a == `ECR_PH_B_FACT_OFS ||
          a == `ECR_PH_C_FACT_OFS)
        present_at = (v == `ECR_VAR_FUND);
      if (a == `ECR_PH_B_FACT_GAIN || a == `ECR_PH_C_FACT_GAIN)
        present_at = (v == `ECR_VAR_FUND);
      // RQ6 fundamental reactive group
      if (a >= `ECR_PH_A_FREA_GAIN && a <= `ECR_PH_C_FREA_OFS)
        present_at = (v == `ECR_VAR_FUND);
      // RQ11 reactive threshold high
      if (a == `ECR_REA_THR_HIGH)
        present_at = (v != `ECR_VAR_BASIC);
    end
  endfunction

  // Thresholds are unsigned, all adjust words signed
  function signed_at;
    input [`ECR_ADDR_W-1:0] a;
    begin
      signed_at = (a < `ECR_APP_THR_HIGH);
    end
  endfunction

  assign idx_present = in_range && present_at(reg_addr, VARIANT);
  assign idx_signed  = signed_at(reg_addr);

  // Storage writes and reset
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_reg
      wire [31:0]            my_sum;
      wire [`ECR_ADDR_W-1:0] my_addr;
      wire                   my_present;
      // Sum kept at full width, then cut to the address width on purpose
      assign my_sum     = BASE + g;
      assign my_addr    = my_sum[`ECR_ADDR_W-1:0];
      assign my_present = present_at(my_addr, VARIANT);
      always @(posedge sys_clk or negedge rst_b)
      begin
        if (!rst_b)
        begin
          // RQ1 signed words reset zero
          // RQ10 threshold low resets zero
          bank_reg[g] <= `ECR_RESET_VAL;
        end
        else if (reg_wr && in_range && ({27'h0, idx} == g) && my_present)
        begin
          // RQ14 reserved writes dropped
          bank_reg[g] <= reg_wdata[`ECR_REG_W-1:0];
        end
      end
    end
  endgenerate

  ecr_word_fmt u_fmt (
    .reg_val   (bank_reg[idx]),
    .is_signed (idx_signed),
    .present   (idx_present),
    .word_out  (fmt_word)
  );

  // Registered read word; unmapped reads zero
  always @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata <= {`ECR_WORD_W{1'b0}};
      reg_hit   <= 1'b0;
    end
    else if (reg_rd)
    begin
      reg_rdata <= in_range ? fmt_word : {`ECR_WORD_W{1'b0}};
      reg_hit   <= idx_present;
    end
  end

  // Datapath views, gain then offset per phase
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_ph
      if (g == 0)
      begin : g_a
        // Phase A total active words live outside this bank
        assign total_active_cal[47:0] = 48'h000000000000;
      end
      else
      begin : g_bc
        // RQ2 phase B and C offsets
        assign total_active_cal[g*48 +: 24]      = bank_reg[(g-1)*2];
        assign total_active_cal[g*48+24 +: 24]   = bank_reg[(g-1)*2+1];
      end
      assign total_reactive_cal[g*48 +: 24]    = bank_reg[4+g*2];
      assign total_reactive_cal[g*48+24 +: 24] = bank_reg[5+g*2];
      assign fund_active_cal[g*48 +: 24]       = bank_reg[10+g*2];
      assign fund_active_cal[g*48+24 +: 24]    = bank_reg[11+g*2];
      assign fund_reactive_cal[g*48 +: 24]     = bank_reg[16+g*2];
      assign fund_reactive_cal[g*48+24 +: 24]  = bank_reg[17+g*2];
    end
  endgenerate

  // RQ7 apparent upper then lower
  // RQ8 lower half own register
  assign apparent_power_threshold = {bank_reg[22], bank_reg[23]};
  // RQ9 active threshold joined
  assign active_power_threshold   = {bank_reg[24], bank_reg[25]};
  // RQ11 reactive upper half
  assign reactive_power_threshold_high = bank_reg[26];

endmodule // ecr_cal_bank

// ===== inc/ecr_regs.vh
// Register offsets, word formats and variant codes for the calibration bank
// Contract
// RQ1 - Every per-phase power gain and offset word is a 24-bit signed read/write register that resets to zero.
// RQ2 - Phases B and C each have their own 24-bit active power offset register beside the matching gain register.
// RQ3 - Total reactive gain and offset registers for phases A, B and C exist only in reactive-capable variants.
// RQ4 - The phase A fundamental active gain register exists only in the fundamental-capable variant and is reserved otherwise.
// RQ5 - Fundamental active offset registers for phases A, B and C exist only in the fundamental-capable variant.
// RQ6 - Fundamental reactive gain and offset registers for phases A, B and C exist only in the fundamental-capable variant.
// RQ7 - The 48-bit apparent power threshold is formed with the first unsigned 24-bit register as upper half and the second as lower half.
// RQ8 - The apparent threshold lower half comes from its own unsigned 24-bit register feeding the apparent datapath.
// RQ9 - The 48-bit active threshold, shared by total and fundamental active datapaths, joins an upper and a lower 24-bit register.
// RQ10 - The lower 24 bits of the active threshold sit in an unsigned register that resets to zero.
// RQ11 - The upper 24 bits of the reactive threshold sit in an unsigned register present only in reactive-capable variants.
// RQ12 - A signed 24-bit register travels as a 32-bit word with bits 31:28 zero and bits 27:24 copying the sign.
// RQ13 - An unsigned 24-bit threshold register travels as a 32-bit word with its top eight bits zero.
// RQ14 - Writes to locations reserved in the current variant are ignored and such locations read as zero.
`ifndef ECR_REGS_VH
`define ECR_REGS_VH

`define ECR_ADDR_W      16
`define ECR_REG_W       24
`define ECR_WORD_W      32
`define ECR_THR_W       48
`define ECR_RESET_VAL   24'h000000

`define ECR_BASE        16'h4393
`define ECR_LAST        16'h43ad
`define ECR_NUM_REGS    27

`define ECR_PH_B_ACT_GAIN   16'h4393
`define ECR_PH_B_ACT_OFS    16'h4394
`define ECR_PH_C_ACT_GAIN   16'h4395
`define ECR_PH_C_ACT_OFS    16'h4396
`define ECR_PH_A_REA_GAIN   16'h4397
`define ECR_PH_A_REA_OFS    16'h4398
`define ECR_PH_B_REA_GAIN   16'h4399
`define ECR_PH_B_REA_OFS    16'h439a
`define ECR_PH_C_REA_GAIN   16'h439b
`define ECR_PH_C_REA_OFS    16'h439c
`define ECR_PH_A_FACT_GAIN  16'h439d
`define ECR_PH_A_FACT_OFS   16'h439e
`define ECR_PH_B_FACT_GAIN  16'h439f
`define ECR_PH_B_FACT_OFS   16'h43a0
`define ECR_PH_C_FACT_GAIN  16'h43a1
`define ECR_PH_C_FACT_OFS   16'h43a2
`define ECR_PH_A_FREA_GAIN  16'h43a3
`define ECR_PH_A_FREA_OFS   16'h43a4
`define ECR_PH_B_FREA_GAIN  16'h43a5
`define ECR_PH_B_FREA_OFS   16'h43a6
`define ECR_PH_C_FREA_GAIN  16'h43a7
`define ECR_PH_C_FREA_OFS   16'h43a8
`define ECR_APP_THR_HIGH    16'h43a9
`define ECR_APP_THR_LOW     16'h43aa
`define ECR_ACT_THR_HIGH    16'h43ab
`define ECR_ACT_THR_LOW     16'h43ac
`define ECR_REA_THR_HIGH    16'h43ad

`define ECR_SIGN_BIT        23
`define ECR_PAD_HI_W        4
`define ECR_SIGN_EXT_W      4
`define ECR_ZP_PAD_W        8

`define ECR_VAR_BASIC       2'h0
`define ECR_VAR_REACTIVE    2'h1
`define ECR_VAR_NEUTRAL     2'h2
`define ECR_VAR_FUND        2'h3

`endif

// ===== hdl/ecr_word_fmt.v
// Packs a 24-bit register value into its 32-bit transfer word
`timescale 1ns/1ps
`include "ecr_regs.vh"

module ecr_word_fmt (
  input  wire [`ECR_REG_W-1:0]  reg_val,
  input  wire                   is_signed,
  input  wire                   present,
  output reg  [`ECR_WORD_W-1:0] word_out
);

  always @*
  begin
    if (!present)
    begin
      // RQ14 reserved reads zero
      word_out = {`ECR_WORD_W{1'b0}};
    end
    else if (is_signed)
    begin
      // RQ12 sign extend four bits
      word_out = {{`ECR_PAD_HI_W{1'b0}},
                  {`ECR_SIGN_EXT_W{reg_val[`ECR_SIGN_BIT]}}, reg_val};
    end
    else
    begin
      // RQ13 zero pad eight bits
      word_out = {{`ECR_ZP_PAD_W{1'b0}}, reg_val};
    end
  end

endmodule // ecr_word_fmt

// ===== test/ecr_cal_bank_asserts.sv
// Port assertions for the calibration bank
`timescale 1ns/1ps
module ecr_cal_bank_asserts #(parameter [1:0] VARIANT = 2'h3) (
  input        sys_clk,
  input        rst_b,
  input [15:0] reg_addr,
  input        reg_wr,
  input        reg_rd,
  input [31:0] reg_wdata,
  input [31:0] reg_rdata,
  input        reg_hit,
  input [143:0] total_active_cal,
  input [143:0] total_reactive_cal,
  input [47:0] apparent_power_threshold,
  input [47:0] active_power_threshold,
  input [23:0] reactive_power_threshold_high
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  a_sign_pad: assert property ($past(reg_rd) && reg_hit &&
    $past(reg_addr) < 16'h43a9 |-> reg_rdata[31:24] ==
    {4'h0, {4{reg_rdata[23]}}}) else $error("bad sign pad");
  a_zero_pad: assert property ($past(reg_rd) &&
    $past(reg_addr) > 16'h43a8 |-> ~|reg_rdata[31:24]) else $error("zero pad");
  a_rsvd_zero: assert property (reg_rd && (reg_addr < 16'h4393 ||
    reg_addr > 16'h43ad || (VARIANT != 2'h3 && reg_addr > 16'h439c &&
    reg_addr < 16'h43a9)) |=> !reg_hit && ~|reg_rdata) else $error("rsvd");
  a_app_high: assert property (reg_wr && reg_addr == 16'h43a9 |=>
    apparent_power_threshold[47:24] == $past(reg_wdata[23:0]))
    else $error("apparent high");
  a_app_low: assert property (reg_wr && reg_addr == 16'h43aa |=>
    apparent_power_threshold[23:0] == $past(reg_wdata[23:0]))
    else $error("apparent low");
  a_act_high: assert property (reg_wr && reg_addr == 16'h43ab |=>
    active_power_threshold[47:24] == $past(reg_wdata[23:0]))
    else $error("active high");
  a_act_low: assert property (reg_wr && reg_addr == 16'h43ac |=>
    active_power_threshold[23:0] == $past(reg_wdata[23:0]))
    else $error("active low");
  a_rea_high: assert property (VARIANT != 2'h0 && reg_wr &&
    reg_addr == 16'h43ad |=> reactive_power_threshold_high ==
    $past(reg_wdata[23:0])) else $error("reactive high");
  a_act_cal_view: assert property (reg_wr && reg_addr >= 16'h4393 &&
    reg_addr <= 16'h4396 |=> total_active_cal[($past(reg_addr) - 16'h4393)
    * 24 + 48 +: 24] == $past(reg_wdata[23:0])) else $error("active cal");
  a_rea_cal_view: assert property (VARIANT != 2'h0 && reg_wr &&
    reg_addr >= 16'h4397 && reg_addr <= 16'h439c |=> total_reactive_cal[
    ($past(reg_addr) - 16'h4397) * 24 +: 24] == $past(reg_wdata[23:0]))
    else $error("reactive cal");
endmodule // ecr_cal_bank_asserts
bind ecr_cal_bank ecr_cal_bank_asserts #(.VARIANT(VARIANT)) ecr_asserts_i (
  .sys_clk, .rst_b, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
  .reg_hit, .total_active_cal, .total_reactive_cal,
  .apparent_power_threshold, .active_power_threshold,
  .reactive_power_threshold_high);

// ===== test/ecr_host_model.sv
// Host model that drives register strobes into the bank
`timescale 1ns/1ps
module ecr_host_model (
  input  logic        sys_clk,
  output logic [15:0] reg_addr = 16'h0,
  output logic        reg_wr = 1'b0,
  output logic        reg_rd = 1'b0,
  output logic [31:0] reg_wdata = 32'h0
);
  // whole words; released lines inverted so stale data fails
  task xfer(logic w, logic [15:0] a, logic [31:0] d);
    @(posedge sys_clk);
    #2 {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(posedge sys_clk);
    #2 {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask
endmodule // ecr_host_model

// ===== test/tb_ecr_cal_bank.sv
// Self-checking bench for the calibration bank
`timescale 1ns/1ps
module tb_ecr_cal_bank;
  logic        sys_clk = 1'b0, rst_b = 1'b0;
  logic        reg_wr, reg_rd, reg_hit;
  logic [15:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, w;
  logic [32:0] exp_q[$], note, d;
  int          err_count = 0, checks_done = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  ecr_host_model ecr_host_model_i (.sys_clk, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata);
  ecr_cal_bank #(.VARIANT(2'h1)) ecr_cal_bank_i (.sys_clk, .rst_b,
    .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_hit,
    .total_active_cal(), .total_reactive_cal(), .fund_active_cal(),
    .fund_reactive_cal(), .apparent_power_threshold(),
    .active_power_threshold(), .reactive_power_threshold_high());
  function automatic logic [32:0] fmt(logic [15:0] a, logic [23:0] v);
    return (a < 16'h4393 || a > 16'h43ad || (a > 16'h439c && a < 16'h43a9))
      ? 33'h0 : a > 16'h43a8 ? {9'h100, v} : {5'h10, {4{v[23]}}, v};
  endfunction
  task rd(logic [15:0] a, logic [23:0] v);
    exp_q.push_back(fmt(a, v));
    ecr_host_model_i.xfer(1'b0, a, 32'h0);
  endtask
  task tally_and_finish(int late);
    err_count += late;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    if (++cyc == 1000)
      tally_and_finish(1);
    if (reg_rd === 1'b1)
    begin
      #1 note = exp_q.pop_front();
      checks_done++;
      if (note !== {reg_hit, reg_rdata})
      begin
        err_count++;
        $display("wrong value %0t %h %h", $time, {reg_hit, reg_rdata}, note);
      end
    end
  end
  initial
  begin
    void'($urandom(14));
    repeat (12) @(posedge sys_clk);
    #2 rst_b = 1'b1;
    for (int a = 16'h4392; a < 16'h43af; a++)
    begin
      rd(a[15:0], 24'h0);
      w = $urandom();
      d = fmt(a[15:0], w[23:0]);
      ecr_host_model_i.xfer(1'b1, a[15:0], d[32] ? d[31:0] : w);
      rd(a[15:0], w[23:0]);
    end
    repeat (3) @(posedge sys_clk);
    tally_and_finish(0);
  end
endmodule // tb_ecr_cal_bank
